/* File: rtl/pvc_cfg.svh */
`ifndef PVC_CFG_SVH
`define PVC_CFG_SVH
// ==========================================
// Register byte offsets
`define PVC_A_CMD 8'h00
`define PVC_A_PIN0 8'h04
`define PVC_A_PIN1 8'h08
`define PVC_A_NEW0 8'h0C
`define PVC_A_NEW1 8'h10
`define PVC_A_STAT 8'h14
`define PVC_A_ACC 8'h18
`define PVC_A_QUAL 8'h1C
`define PVC_A_SLOT 8'h20
// ==========================================
// Command word fields
`define PVC_F_OP 7:0
`define PVC_F_P1 15:8
`define PVC_F_P2 23:16
`define PVC_F_LC 31:24
`define PVC_OP_VERIFY 8'h00
`define PVC_OP_CHANGE 8'h01
`define PVC_OP_DISABLE 8'h02
`define PVC_LC_EMPTY 8'h00
`define PVC_LC_PIN 8'h08
`define PVC_LC_CHANGE 8'h10
// ==========================================
// Status words
`define PVC_SW_OK 16'h9000
`define PVC_SW_RETRY 12'h63C
`define PVC_SW_BLOCKED 16'h6983
`define PVC_SW_COND 16'h6985
`define PVC_SW_P1P2 16'h6A86
`define PVC_SW_LEN 16'h6700
`define PVC_SW_INS 16'h6D00
// ==========================================
// Values
`define PVC_NSLOT 4
`define PVC_TRIES_INIT 2'h3
`define PVC_QUAL_USE 8'h08
`define PVC_QUAL_NONE 8'h00
`define PVC_PIN_DEFAULT 64'h3132333435363738
`define PVC_RESP_OK 2'h0
`define PVC_RESP_SLVERR 2'h2
`endif

/* File: rtl/pvc_pin_slot.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pvc_cfg.svh"
module pvc_pin_slot
   import pvc_pkg::*;
(
   // Clock and resets
   input wire logic clk_i,
   input wire logic rst_ni,
   input wire logic init_i,
   // Actions
   input wire logic ok_i,
   input wire logic fail_i,
   input wire logic load_i,
   input wire logic dis_i,
   input wire logic repl_en_i,
   input wire logic [1:0] repl_idx_i,
   input wire logic qual_set_i,
   input wire pvc_pkg::pvc_pin_t pin_i,
   input wire pvc_pkg::pvc_pin_t new_pin_i,
   // State
   output logic match_o,
   output pvc_pkg::pvc_cnt_t cnt_o,
   output logic blocked_o,
   output logic disabled_o,
   output logic verified_o,
   output logic repl_v_o,
   output logic [1:0] repl_idx_o,
   output logic [7:0] qual_o
);
   // Non-volatile part: kept across session resets, only a factory load resets it
   pvc_pin_t pin_q, pin_d;
   pvc_cnt_t cnt_q, cnt_d;
   logic blk_q, blk_d, dis_q, dis_d, rv_q, rv_d, ver_q, ver_d;
   logic [1:0] ri_q, ri_d;
   logic [7:0] qual_q, qual_d;

   always_comb
   begin
      pin_d = pin_q;
      cnt_d = cnt_q;
      blk_d = blk_q;
      dis_d = dis_q;
      rv_d = rv_q;
      ri_d = ri_q;
      qual_d = qual_q;
      ver_d = ver_q;
      if (init_i)
      begin
         pin_d = `PVC_PIN_DEFAULT;
         cnt_d = `PVC_TRIES_INIT;
         blk_d = 1'b0;
         dis_d = 1'b0;
         rv_d = 1'b0;
         ri_d = 2'h0;
         qual_d = `PVC_QUAL_NONE;
         ver_d = 1'b0;
      end
      else
      begin
         if (ok_i)
         begin
            cnt_d = `PVC_TRIES_INIT;
            ver_d = 1'b1;
         end
         if (fail_i)
         begin
            cnt_d = cnt_q - 2'h1;
            blk_d = (cnt_q == 2'h1);
            ver_d = 1'b0;
         end
         if (load_i)
            pin_d = new_pin_i;
         if (dis_i)
         begin
            dis_d = 1'b1;
            rv_d = repl_en_i;
            ri_d = repl_idx_i;
         end
         if (qual_set_i)
            qual_d = `PVC_QUAL_USE;
      end
   end

   always_ff @(posedge clk_i)
   begin
      pin_q <= pin_d;
      cnt_q <= cnt_d;
      blk_q <= blk_d;
      dis_q <= dis_d;
      rv_q <= rv_d;
      ri_q <= ri_d;
      qual_q <= qual_d;
   end

   // Verified status is session state and is lost on reset
   always_ff @(posedge clk_i or negedge rst_ni)
   begin
      if (!rst_ni)
         ver_q <= 1'b0;
      else
         ver_q <= ver_d;
   end

   assign match_o = (pin_i == pin_q);
   assign cnt_o = cnt_q;
   assign blocked_o = blk_q;
   assign disabled_o = dis_q;
   assign verified_o = ver_q;
   assign repl_v_o = rv_q;
   assign repl_idx_o = ri_q;
   assign qual_o = qual_q;
endmodule // pvc_pin_slot
`default_nettype wire

/* File: rtl/pvc_pkg.sv */
package pvc_pkg;
   typedef enum logic [0:0] {ST_IDLE, ST_EXEC} pvc_state_t;
   typedef logic [63:0] pvc_pin_t;
   typedef logic [1:0] pvc_cnt_t;
   typedef logic [15:0] pvc_sw_t;
endpackage

/* File: rtl/pvc_top.sv */
// Notes on behaviour
// - PIN compare; status shared by all channels
// - Verify with data only if enabled, unblocked
// - PIN-gated access needs verification unless disabled
// - Correct verify restores counter to three
// - Wrong verify decrements counter, any channel
// - Wrong answers 63C2, 63C1, then block, 63C0
// - Counter and blocked state survive power loss
// - Verify with data on blocked PIN: 6983
// - Blocked PIN never grants until unblocked
// - Empty verify returns 63CX in any state
// - Empty verify on blocked PIN gives 63C0
// - Reference byte: scope bit, 00, number, nonzero
// - Correct change: counter three, new PIN stored
// - Wrong change: decrement, PIN kept, three block
// - Replacement key qualifier set to 08
// - Access re-evaluated after successful disable
// - Disabled PIN frees files unless replaced
// - Several refs: any disabled, unreplaced one grants access
// - Disable refused when disabled or blocked
// - Correct disable: counter three, PIN disabled
// - Wrong disable: decrement, stays enabled, block
// - Disable P1: replace bit, 00, key number
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "pvc_cfg.svh"
module pvc_top
   import pvc_pkg::*;
(
   // Clock and reset
   input wire logic CLK_I,
   input wire logic NRST_I,
   // Factory load of stored PIN data
   input wire logic FACTORY_INIT_I,
   // AXI4-Lite write
   input wire logic [7:0] AWADDR_I,
   input wire logic AWVALID_I,
   output logic AWREADY_O,
   input wire logic [31:0] WDATA_I,
   input wire logic [3:0] WSTRB_I,
   input wire logic WVALID_I,
   output logic WREADY_O,
   output logic [1:0] BRESP_O,
   output logic BVALID_O,
   input wire logic BREADY_I,
   // AXI4-Lite read
   input wire logic [7:0] ARADDR_I,
   input wire logic ARVALID_I,
   output logic ARREADY_O,
   output logic [31:0] RDATA_O,
   output logic [1:0] RRESP_O,
   output logic RVALID_O,
   input wire logic RREADY_I,
   // Access result
   output logic GRANT_O
);
   import pvc_pkg::*;

   // ==========================================
   // Reset release
   logic rst_s1_q, rst_n;
   always_ff @(posedge CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         rst_s1_q <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_n <= rst_s1_q;
      end
   end

   // ==========================================
   // Bus slave
   logic [31:0] cmd_q, cmd_d, pin0_q, pin0_d, pin1_q, pin1_d;
   logic [31:0] new0_q, new0_d, new1_q, new1_d, rdata_q, rdata_d;
   logic [3:0] acc_q, acc_d;
   logic bvalid_q, bvalid_d, rvalid_q, rvalid_d, go_q, go_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic wr_take, rd_take, wr_hit, rd_hit;
   logic [31:0] rd_word, stat_word, qual_word, slot_word;
   pvc_sw_t sw_q, sw_d;
   logic grant_q, grant_d;
   pvc_cnt_t cnt_a [`PVC_NSLOT];
   logic blk_a [`PVC_NSLOT];
   logic dis_a [`PVC_NSLOT];
   logic ver_a [`PVC_NSLOT];
   logic match_a [`PVC_NSLOT];
   logic rv_a [`PVC_NSLOT];
   logic [1:0] ri_a [`PVC_NSLOT];
   logic [7:0] qual_a [`PVC_NSLOT];

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
         if (strb[b])
            r[b*8 +: 8] = nw[b*8 +: 8];
      return r;
   endfunction

   assign wr_take = AWVALID_I && WVALID_I && !bvalid_q;
   assign rd_take = ARVALID_I && !rvalid_q;
   assign AWREADY_O = wr_take;
   assign WREADY_O = wr_take;
   assign ARREADY_O = rd_take;
   assign wr_hit = (AWADDR_I[1:0] == 2'h0) && (AWADDR_I <= `PVC_A_ACC)
                   && (AWADDR_I != `PVC_A_STAT);
   assign rd_hit = (ARADDR_I[1:0] == 2'h0) && (ARADDR_I <= `PVC_A_SLOT);

   always_comb
   begin
      stat_word = {15'h0, grant_q, sw_q};
      for (int i = 0; i < `PVC_NSLOT; i++)
      begin
         qual_word[i*8 +: 8] = qual_a[i];
         slot_word[i*8 +: 8] = {3'h0, ver_a[i], dis_a[i], blk_a[i], cnt_a[i]};
      end
      case (ARADDR_I)
         `PVC_A_CMD: rd_word = cmd_q;
         `PVC_A_STAT: rd_word = stat_word;
         `PVC_A_ACC: rd_word = {28'h0, acc_q};
         `PVC_A_QUAL: rd_word = qual_word;
         `PVC_A_SLOT: rd_word = slot_word;
         default: rd_word = 32'h0;
      endcase
   end

   always_comb
   begin
      cmd_d = cmd_q;
      pin0_d = pin0_q;
      pin1_d = pin1_q;
      new0_d = new0_q;
      new1_d = new1_q;
      acc_d = acc_q;
      go_d = 1'b0;
      bvalid_d = bvalid_q && !BREADY_I;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q && !RREADY_I;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      if (wr_take)
      begin
         bvalid_d = 1'b1;
         bresp_d = wr_hit ? `PVC_RESP_OK : `PVC_RESP_SLVERR;
         case (AWADDR_I)
            `PVC_A_CMD:
            begin
               cmd_d = merge(cmd_q, WDATA_I, WSTRB_I);
               go_d = 1'b1;
            end
            `PVC_A_PIN0: pin0_d = merge(pin0_q, WDATA_I, WSTRB_I);
            `PVC_A_PIN1: pin1_d = merge(pin1_q, WDATA_I, WSTRB_I);
            `PVC_A_NEW0: new0_d = merge(new0_q, WDATA_I, WSTRB_I);
            `PVC_A_NEW1: new1_d = merge(new1_q, WDATA_I, WSTRB_I);
            `PVC_A_ACC: acc_d = 4'(merge({28'h0, acc_q}, WDATA_I, WSTRB_I));
            default: ;
         endcase
      end
      if (rd_take)
      begin
         rvalid_d = 1'b1;
         rresp_d = rd_hit ? `PVC_RESP_OK : `PVC_RESP_SLVERR;
         rdata_d = rd_hit ? rd_word : 32'h0;
      end
   end

   always_ff @(posedge CLK_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cmd_q <= 32'h0;
         pin0_q <= 32'h0;
         pin1_q <= 32'h0;
         new0_q <= 32'h0;
         new1_q <= 32'h0;
         acc_q <= 4'h0;
         go_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= `PVC_RESP_OK;
         rvalid_q <= 1'b0;
         rresp_q <= `PVC_RESP_OK;
         rdata_q <= 32'h0;
      end
      else
      begin
         cmd_q <= cmd_d;
         pin0_q <= pin0_d;
         pin1_q <= pin1_d;
         new0_q <= new0_d;
         new1_q <= new1_d;
         acc_q <= acc_d;
         go_q <= go_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
      end
   end

   assign BVALID_O = bvalid_q;
   assign BRESP_O = bresp_q;
   assign RVALID_O = rvalid_q;
   assign RRESP_O = rresp_q;
   assign RDATA_O = rdata_q;

   // ==========================================
   // Command engine
   pvc_state_t st_q, st_d;
   logic [7:0] op, p1, p2, lc;
   logic ref_ok, rk_ok, exec;
   logic [1:0] slot, rslot;
   logic s_cnt_hi, s_blk, s_dis, s_match;
   pvc_cnt_t s_cnt;
   logic do_ok, do_fail, do_load, do_dis, do_repl;
   logic [`PVC_NSLOT-1:0] ok_v, fail_v, load_v, dis_v, qual_v;

   assign op = cmd_q[`PVC_F_OP];
   assign p1 = cmd_q[`PVC_F_P1];
   assign p2 = cmd_q[`PVC_F_P2];
   assign lc = cmd_q[`PVC_F_LC];
   assign exec = (st_q == ST_EXEC);
   // Reference numbers 1 to 4 map onto the four slots; scope bit is not split
   assign ref_ok = (p2[6:5] == 2'h0) && (p2[4:0] != 5'h0) && (p2[4:0] <= 5'h4);
   assign slot = p2[1:0] - 2'h1;
   assign rk_ok = (p1[4:0] != 5'h0) && (p1[4:0] <= 5'h4);
   assign rslot = p1[1:0] - 2'h1;
   assign s_cnt = cnt_a[slot];
   assign s_blk = blk_a[slot];
   assign s_dis = dis_a[slot];
   assign s_match = match_a[slot];
   assign s_cnt_hi = (s_cnt > 2'h1);

   always_comb
   begin
      st_d = go_q ? ST_EXEC : ST_IDLE;
      sw_d = sw_q;
      do_ok = 1'b0;
      do_fail = 1'b0;
      do_load = 1'b0;
      do_dis = 1'b0;
      do_repl = 1'b0;
      if (exec)
      begin
         if (!ref_ok)
            sw_d = `PVC_SW_P1P2;
         else
            case (op)
               `PVC_OP_VERIFY:
                  if (p1 != 8'h0)
                     sw_d = `PVC_SW_P1P2;
                  else if (lc == `PVC_LC_EMPTY)
                     sw_d = {`PVC_SW_RETRY, 2'h0, s_cnt};
                  else if (lc != `PVC_LC_PIN)
                     sw_d = `PVC_SW_LEN;
                  else if (s_blk)
                     sw_d = `PVC_SW_BLOCKED;
                  else if (s_dis)
                     sw_d = `PVC_SW_COND;
                  else
                  begin
                     do_ok = s_match;
                     do_fail = !s_match;
                  end
               `PVC_OP_CHANGE:
                  if (p1 != 8'h0)
                     sw_d = `PVC_SW_P1P2;
                  else if (lc != `PVC_LC_CHANGE)
                     sw_d = `PVC_SW_LEN;
                  else if (s_blk || s_dis)
                     sw_d = s_blk ? `PVC_SW_BLOCKED : `PVC_SW_COND;
                  else
                  begin
                     do_ok = s_match;
                     do_load = s_match;
                     do_fail = !s_match;
                  end
               `PVC_OP_DISABLE:
                  if (p1[6:5] != 2'h0 || (p1[7] && !rk_ok))
                     sw_d = `PVC_SW_P1P2;
                  else if (lc != `PVC_LC_PIN)
                     sw_d = `PVC_SW_LEN;
                  else if (s_blk || s_dis)
                     sw_d = `PVC_SW_COND;
                  else
                  begin
                     do_ok = s_match;
                     do_dis = s_match;
                     do_repl = s_match && p1[7];
                     do_fail = !s_match;
                  end
               default: sw_d = `PVC_SW_INS;
            endcase
         if (do_ok)
            sw_d = `PVC_SW_OK;
         if (do_fail)
            sw_d = {`PVC_SW_RETRY, 2'h0, s_cnt - 2'h1};
      end
   end

   // Grant is rebuilt every cycle, so a disable is reflected on the next edge
   always_comb
   begin
      grant_d = (acc_q == 4'h0);
      for (int i = 0; i < `PVC_NSLOT; i++)
         if (acc_q[i])
         begin
            if (dis_a[i])
               grant_d = grant_d || !rv_a[i]
                         || (ver_a[ri_a[i]] && !blk_a[ri_a[i]]);
            else
               grant_d = grant_d || (ver_a[i] && !blk_a[i]);
         end
   end

   always_ff @(posedge CLK_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q <= ST_IDLE;
         sw_q <= `PVC_SW_OK;
         grant_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         sw_q <= sw_d;
         grant_q <= grant_d;
      end
   end

   assign GRANT_O = grant_q;

   // ==========================================
   // PIN slots
   always_comb
   begin
      for (int i = 0; i < `PVC_NSLOT; i++)
      begin
         ok_v[i] = do_ok && (slot == i[1:0]);
         fail_v[i] = do_fail && (slot == i[1:0]);
         load_v[i] = do_load && (slot == i[1:0]);
         dis_v[i] = do_dis && (slot == i[1:0]);
         qual_v[i] = do_repl && (rslot == i[1:0]);
      end
   end

   // Counter, blocked flag and stored PIN sit in non-volatile slots
   for (genvar g = 0; g < `PVC_NSLOT; g++)
   begin : g_slot
      pvc_pin_slot u_slot (
         .clk_i(CLK_I), .rst_ni(rst_n), .init_i(FACTORY_INIT_I),
         .ok_i(ok_v[g]), .fail_i(fail_v[g]), .load_i(load_v[g]),
         .dis_i(dis_v[g]), .repl_en_i(do_repl), .repl_idx_i(rslot),
         .qual_set_i(qual_v[g]), .pin_i({pin1_q, pin0_q}), .new_pin_i({new1_q, new0_q}),
         .match_o(match_a[g]), .cnt_o(cnt_a[g]), .blocked_o(blk_a[g]),
         .disabled_o(dis_a[g]), .verified_o(ver_a[g]), .repl_v_o(rv_a[g]),
         .repl_idx_o(ri_a[g]), .qual_o(qual_a[g])
      );
   end

   // ==========================================
   // Checks
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!rst_n || FACTORY_INIT_I);

   a_ok_restore: assert property (do_ok |=> cnt_a[$past(slot)] == 2'h3 && sw_q == 16'h9000)
      else $error("counter not restored on success");
   a_fail_dec: assert property (do_fail && s_cnt_hi |=> cnt_a[$past(slot)] == $past(s_cnt) - 2'h1)
      else $error("counter not decremented");
   a_fail_block: assert property (do_fail && s_cnt == 2'h1 |=> blk_a[$past(slot)] && sw_q == 16'h63C0)
      else $error("third failure did not block");
   a_blocked_sw: assert property (
      exec && ref_ok && op == 8'h00 && p1 == 8'h0 && lc == 8'h08 && s_blk
      |=> sw_q == 16'h6983)
      else $error("blocked PIN not answered 6983");
   a_empty_cnt: assert property (
      exec && ref_ok && op == 8'h00 && p1 == 8'h0 && lc == 8'h00
      |=> sw_q[15:4] == 12'h63C && sw_q[1:0] == $past(s_cnt))
      else $error("empty verify wrong status");
   a_gate_state: assert property (do_ok || do_fail |-> !s_dis && !s_blk)
      else $error("compare on disabled or blocked PIN");
   a_refuse_keep: assert property (
      exec && ref_ok && op == 8'h02 && p1[6:5] == 2'h0 && (!p1[7] || rk_ok)
      && lc == 8'h08 && (s_dis || s_blk)
      |=> cnt_a[$past(slot)] == $past(s_cnt) && sw_q == 16'h6985)
      else $error("refused disable touched state");
   a_qual_use: assert property (do_repl |=> qual_a[$past(rslot)] == 8'h08 && dis_a[$past(slot)])
      else $error("replacement qualifier not set");
   a_block_deny: assert property (acc_q == 4'h1 && blk_a[0] && !dis_a[0] |=> !grant_q)
      else $error("blocked PIN granted access");

   c_verify_ok: cover property (do_ok && op == 8'h00);
   c_block: cover property (do_fail && s_cnt == 2'h1);
   c_repl: cover property (do_repl ##1 grant_q);
endmodule // pvc_top
`default_nettype wire

/* File: verif/pvc_term.sv */
`timescale 1ns/1ps
`default_nettype none
module pvc_term
(
   // Clock
   input wire logic clk_i,
   // Write channels
   output logic [7:0] awaddr_o,
   output logic awvalid_o,
   input wire logic awready_i,
   output logic [31:0] wdata_o,
   output logic wvalid_o,
   input wire logic wready_i,
   input wire logic [1:0] bresp_i,
   input wire logic bvalid_i,
   output logic bready_o,
   // Read channels
   output logic [7:0] araddr_o,
   output logic arvalid_o,
   input wire logic arready_i,
   input wire logic [31:0] rdata_i,
   input wire logic [1:0] rresp_i,
   input wire logic rvalid_i,
   output logic rready_o
);
   // ====================
   // Idle bus
   initial
   begin
      awaddr_o = 8'h00;
      awvalid_o = 1'b0;
      wdata_o = 32'h0;
      wvalid_o = 1'b0;
      bready_o = 1'b0;
      araddr_o = 8'h00;
      arvalid_o = 1'b0;
      rready_o = 1'b0;
   end
   // ====================
   // Transfers, entered just after a rising edge
   // Each channel held until its own ready, so any slave order works
   // Response readies stay high afterwards; each call sets its own ready high again
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      awaddr_o <= a;
      awvalid_o <= 1'b1;
      wdata_o <= d;
      wvalid_o <= 1'b1;
      bready_o <= 1'b1;
      while (!(aw_done && w_done))
      begin
         @(posedge clk_i);
         if (!aw_done && awready_i)
         begin
            aw_done = 1'b1;
            awvalid_o <= 1'b0;
         end
         if (!w_done && wready_i)
         begin
            w_done = 1'b1;
            wvalid_o <= 1'b0;
         end
      end
      do @(posedge clk_i); while (!bvalid_i);
      r = bresp_i;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr_o <= a;
      arvalid_o <= 1'b1;
      rready_o <= 1'b1;
      do @(posedge clk_i); while (!arready_i);
      arvalid_o <= 1'b0;
      do @(posedge clk_i); while (!rvalid_i);
      d = rdata_i;
      r = rresp_i;
   endtask
endmodule // pvc_term
`default_nettype wire

/* File: verif/tb_pin_verify_change_disable.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pvc_cfg.svh"
module tb_pin_verify_change_disable;
   import pvc_pkg::*;
   // ====================
   // Signals
   logic clk;
   logic nrst;
   logic finit;
   logic grant;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd, lfsr_q;
   logic [1:0] bresp, rresp, resp;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   int fail_count;
   int check_count;
   pvc_pin_t dflt;
   pvc_pin_t pin_new;
   pvc_term u_term (.clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
      .wdata_o(wdata), .wvalid_o(wvalid), .wready_i(wready), .bresp_i(bresp),
      .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid),
      .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp), .rvalid_i(rvalid),
      .rready_o(rready));
   pvc_top u_dut (.CLK_I(clk), .NRST_I(nrst), .FACTORY_INIT_I(finit), .AWADDR_I(awaddr),
      .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(4'hF),
      .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid),
      .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
      .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
      .GRANT_O(grant));
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ====================
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic pvc_sw_t retry(input int n);
      return {`PVC_SW_RETRY, 4'(n)};
   endfunction
   task automatic end_sim();
      if (fail_count == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      u_term.wr(a, d, resp);
      chk("bresp", {30'h0, er}, {30'h0, resp});
   endtask
   task automatic rreg(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      u_term.rd(a, rd, resp);
      chk("rdata", ed, rd);
      chk("rresp", {30'h0, er}, {30'h0, resp});
   endtask
   task automatic pin(input pvc_pin_t p, input pvc_pin_t n);
      wreg(`PVC_A_PIN0, p[31:0], `PVC_RESP_OK);
      wreg(`PVC_A_PIN1, p[63:32], `PVC_RESP_OK);
      wreg(`PVC_A_NEW0, n[31:0], `PVC_RESP_OK);
      wreg(`PVC_A_NEW1, n[63:32], `PVC_RESP_OK);
   endtask
   // Status is only valid two edges after the command is taken
   task automatic cmd(input logic [7:0] op, p1, p2, lc, input pvc_sw_t esw);
      wreg(`PVC_A_CMD, {lc, p2, p1, op}, `PVC_RESP_OK);
      repeat (2) @(posedge clk);
      u_term.rd(`PVC_A_STAT, rd, resp);
      chk("status", {16'h0, esw}, {16'h0, rd[15:0]});
   endtask
   // Grant lags the slot state by a cycle
   task automatic acc(input logic [3:0] m, input logic eg);
      wreg(`PVC_A_ACC, {28'h0, m}, `PVC_RESP_OK);
      repeat (3) @(posedge clk);
      chk("grant", {31'h0, eg}, {31'h0, grant});
   endtask
   // ====================
   // Watchdog
   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      $display("MISMATCH watchdog expected done seen timeout");
      end_sim();
   end
   // ====================
   // Sequence
   initial
   begin
      nrst = 1'b0;
      finit = 1'b0;
      fail_count = 0;
      check_count = 0;
      lfsr_q = 32'h2CCEA472;
      dflt = `PVC_PIN_DEFAULT;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      finit <= 1'b1;
      @(posedge clk);
      finit <= 1'b0;
      repeat (3) @(posedge clk);
      rreg(8'h24, 32'h0, `PVC_RESP_SLVERR);
      wreg(`PVC_A_STAT, 32'h0, `PVC_RESP_SLVERR);
      acc(4'h1, 1'b0);
      pin(dflt, dflt);
      cmd(`PVC_OP_VERIFY, 8'h00, 8'h01, `PVC_LC_EMPTY, retry(3));
      cmd(`PVC_OP_VERIFY, 8'h00, 8'h01, `PVC_LC_PIN, `PVC_SW_OK);
      acc(4'h1, 1'b1);
      lfsr_q = lfsr(lfsr_q);
      pin(dflt ^ {32'h0, lfsr_q | 32'h1}, dflt);
      for (int i = 0; i < 3; i++)
      begin
         cmd(`PVC_OP_VERIFY, 8'h00, 8'h01, `PVC_LC_PIN, retry(2 - i));
      end
      acc(4'h1, 1'b0);
      pin(dflt, dflt);
      cmd(`PVC_OP_VERIFY, 8'h00, 8'h01, `PVC_LC_PIN, `PVC_SW_BLOCKED);
      cmd(`PVC_OP_VERIFY, 8'h00, 8'h01, `PVC_LC_EMPTY, retry(0));
      cmd(`PVC_OP_DISABLE, 8'h00, 8'h01, `PVC_LC_PIN, `PVC_SW_COND);
      cmd(`PVC_OP_CHANGE, 8'h00, 8'h01, `PVC_LC_CHANGE, `PVC_SW_BLOCKED);
      rreg(`PVC_A_SLOT, 32'h03030304, `PVC_RESP_OK);
      lfsr_q = lfsr(lfsr_q);
      pin_new = {lfsr_q, ~lfsr_q};
      pin(dflt, pin_new);
      cmd(`PVC_OP_CHANGE, 8'h00, 8'h82, `PVC_LC_CHANGE, `PVC_SW_OK);
      pin(dflt, dflt);
      cmd(`PVC_OP_VERIFY, 8'h00, 8'h82, `PVC_LC_PIN, retry(2));
      pin(pin_new, dflt);
      cmd(`PVC_OP_CHANGE, 8'h00, 8'h03, `PVC_LC_CHANGE, retry(2));
      pin(dflt, dflt);
      cmd(`PVC_OP_VERIFY, 8'h00, 8'h03, `PVC_LC_PIN, `PVC_SW_OK);
      cmd(`PVC_OP_VERIFY, 8'h00, 8'h00, `PVC_LC_EMPTY, `PVC_SW_P1P2);
      cmd(`PVC_OP_VERIFY, 8'h00, 8'h05, `PVC_LC_EMPTY, `PVC_SW_P1P2);
      cmd(`PVC_OP_VERIFY, 8'h00, 8'h03, 8'h04, `PVC_SW_LEN);
      cmd(8'h07, 8'h00, 8'h03, `PVC_LC_PIN, `PVC_SW_INS);
      cmd(`PVC_OP_DISABLE, 8'h20, 8'h03, `PVC_LC_PIN, `PVC_SW_P1P2);
      pin(pin_new, dflt);
      cmd(`PVC_OP_DISABLE, 8'h00, 8'h04, `PVC_LC_PIN, retry(2));
      pin(dflt, dflt);
      cmd(`PVC_OP_DISABLE, 8'h00, 8'h04, `PVC_LC_PIN, `PVC_SW_OK);
      cmd(`PVC_OP_DISABLE, 8'h00, 8'h04, `PVC_LC_PIN, `PVC_SW_COND);
      cmd(`PVC_OP_VERIFY, 8'h00, 8'h04, `PVC_LC_PIN, `PVC_SW_COND);
      cmd(`PVC_OP_VERIFY, 8'h00, 8'h04, `PVC_LC_EMPTY, retry(3));
      acc(4'h8, 1'b1);
      acc(4'h9, 1'b1);
      cmd(`PVC_OP_DISABLE, 8'h82, 8'h03, `PVC_LC_PIN, `PVC_SW_OK);
      rreg(`PVC_A_QUAL, 32'h00000800, `PVC_RESP_OK);
      acc(4'h4, 1'b0);
      pin(pin_new, dflt);
      cmd(`PVC_OP_VERIFY, 8'h00, 8'h82, `PVC_LC_PIN, `PVC_SW_OK);
      acc(4'h4, 1'b1);
      // Session reset: verified flags go, stored state stays
      nrst <= 1'b0;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      acc(4'h4, 1'b0);
      for (int i = 0; i < 8; i++)
      begin
         lfsr_q = lfsr(lfsr_q);
         cmd(`PVC_OP_VERIFY, 8'h00, {lfsr_q[7], 5'h00, lfsr_q[1:0]} + 8'h01, `PVC_LC_EMPTY,
            retry(lfsr_q[1:0] == 2'h0 ? 0 : 3));
      end
      end_sim();
   end
endmodule // tb_pin_verify_change_disable
`default_nettype wire
